// File: logic/sgc_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef SGC_MAP_SVH
`define SGC_MAP_SVH
`define SGC_OFS_GAIN        8'h00
`define SGC_OFS_GCFG        8'h01
`define SGC_GCFG_RESET      8'hC0
`define SGC_GAIN_RESET      8'h00
`define SGC_BIT_GP2         7
`define SGC_BIT_GP1         6
`define SGC_BIT_HOLD        5
`define SGC_BIT_INIT        4
`define SGC_BIT_PFCLR       3
`define SGC_BIT_SLOW        2
`define SGC_BIT_GAIN_LOOP_DISABLE      1
`define SGC_BIT_IFSEL       0
`define SGC_BIT_LVLSHIFT    5
`define SGC_GAIN_MASK       8'h3F
`define SGC_INIT_CYCLES     4
`endif

// File: logic/sgc_pkg.sv
// types shared by the sound-IF configuration register block
package sgc_pkg;
    typedef enum logic [2:0] {
        SGC_RUN   = 3'b001,
        SGC_INIT  = 3'b010,
        SGC_HOLD  = 3'b100
    } sgc_state_t;
endpackage

// File: logic/sgc_regs.sv
// sound-IF gain register and general configuration register
`timescale 1ns/10ps
`include "sgc_map.svh"

module sgc_regs
    import sgc_pkg::*;
#(
    parameter int INIT_CYCLES = `SGC_INIT_CYCLES
) (
    input  wire logic       sys_clk_in,          // 125 MHz system clock
    input  wire logic       rst_in,              // async power-on reset, high
    input  wire logic       wr_en_in,            // register write strobe
    input  wire logic       rd_en_in,            // register read strobe
    input  wire logic [7:0] addr_in,             // register subaddress
    input  wire logic [7:0] wr_data_in,          // write data
    input  wire logic       status_rd_in,        // status register read strobe
    input  wire logic       power_fail_event_in, // supply dip detected
    input  wire logic [4:0] loop_gain_code_in,   // gain chosen by loop
    input  wire logic       gp_pin_one_in,       // sensed level, pin 1
    input  wire logic       gp_pin_two_in,       // sensed level, pin 2
    output logic [7:0]      rd_data_out,         // read data
    output logic [7:0]      status_out,          // status bits for status reg
    output logic            gp_pin_one_oe_out,   // pulls pin 1 low when high
    output logic            gp_pin_two_oe_out,   // pulls pin 2 low when high
    output logic            gp_pin_one_o_out,    // pin 1 drive level (always 0)
    output logic            gp_pin_two_o_out,    // pin 2 drive level (always 0)
    output logic            low_power_hold_out,  // standby active
    output logic            init_busy_out,       // re-initialise in progress
    output logic            gain_loop_disable_out, // fixed gain in use
    output logic            gain_loop_slow_decay_out, // slow decay in effect
    output logic            if_input_choice_out, // 1: second IF input
    output logic            input_level_shift_out, // 10 dB attenuator on
    output logic [4:0]      fixed_gain_code_out, // fixed gain code applied
    output logic            power_fail_flag_out  // power-fail flag
);

    sgc_state_t state_reg, state_next;
    logic [7:0] gcfg_reg, gcfg_next;
    logic [7:0] gain_reg, gain_next;
    logic [7:0] keep_reg, keep_next;
    logic [7:0] rd_reg, rd_next;
    logic [7:0] stat_reg, stat_next;
    logic [3:0] cnt_reg, cnt_next;
    logic       pf_reg, pf_next;
    logic       pf_read_reg, pf_read_next;
    wire  [1:0] pin_level;
    logic [4:0] code_sync0_reg, code_sync1_reg, code_sync2_reg;
    logic [4:0] code_hold_reg;
    logic       pfe_sync0_reg, pfe_sync1_reg;
    logic       agc_prev_reg;
    logic [7:0] out_reg, out_next;
    logic [4:0] fcode_reg;

    // request decode
    wire        hit_gcfg   = wr_en_in && (addr_in == `SGC_OFS_GCFG);
    wire        hit_gain   = wr_en_in && (addr_in == `SGC_OFS_GAIN);
    wire        init_req   = hit_gcfg && wr_data_in[`SGC_BIT_INIT];
    wire        hold_bit   = gcfg_reg[`SGC_BIT_HOLD];
    wire        leave_hold = (state_reg == SGC_HOLD) && hit_gcfg && !wr_data_in[`SGC_BIT_HOLD];
    wire        agc_off    = gcfg_reg[`SGC_BIT_GAIN_LOOP_DISABLE];
    wire        agc_turn_off = agc_off && !agc_prev_reg;
    wire [3:0]  init_last  = 4'(INIT_CYCLES - 1);
    wire        init_done  = (state_reg == SGC_INIT) && (cnt_reg == init_last);
    wire [7:0]  init_value = `SGC_GCFG_RESET | keep_reg;
    wire [7:0]  gain_w     = wr_data_in & `SGC_GAIN_MASK;
    // unmapped subaddresses read back zero
    wire [7:0]  rd_sel     = (addr_in == `SGC_OFS_GCFG) ? gcfg_reg :
                             (addr_in == `SGC_OFS_GAIN) ? gain_reg : 8'h00;

    // state and register updates
    always_comb begin
        state_next   = state_reg;
        gcfg_next    = gcfg_reg;
        gain_next    = gain_reg;
        keep_next    = keep_reg;
        cnt_next     = cnt_reg;
        pf_next      = pf_reg;
        pf_read_next = pf_read_reg;
        case (state_reg)
            SGC_RUN: begin
                if (init_req) begin
                    // whole map back to defaults; written ones survive it
                    state_next = SGC_INIT;
                    keep_next  = wr_data_in;
                    gcfg_next  = `SGC_GCFG_RESET | wr_data_in;
                    gain_next  = `SGC_GAIN_RESET;
                    cnt_next   = 4'h0;
                end else if (hit_gcfg) begin
                    gcfg_next = wr_data_in;
                    if (wr_data_in[`SGC_BIT_HOLD]) begin
                        state_next = SGC_HOLD;
                    end
                end else if (hit_gain) begin
                    gain_next = gain_w;
                end else if (agc_turn_off) begin
                    gain_next = {gain_reg[7:5], code_hold_reg};
                end
            end
            SGC_INIT: begin
                cnt_next = cnt_reg + 4'h1;
                if (init_done) begin
                    // init bit drops by itself, other written ones kept over the defaults
                    gcfg_next  = init_value & ~(8'h01 << `SGC_BIT_INIT);
                    state_next = gcfg_next[`SGC_BIT_HOLD] ? SGC_HOLD : SGC_RUN;
                end
            end
            SGC_HOLD: begin
                if (leave_hold) begin
                    // standby exit is a full power-on reset of the map
                    gcfg_next  = `SGC_GCFG_RESET;
                    gain_next  = `SGC_GAIN_RESET;
                    state_next = SGC_RUN;
                end
            end
            default: begin
                state_next = SGC_RUN;
            end
        endcase
        // flag: a new event wins over the clear in the same cycle
        if (pfe_sync1_reg) begin
            pf_next = 1'b1;
        end else if (hit_gcfg && wr_data_in[`SGC_BIT_PFCLR]) begin
            pf_next = 1'b0;
        end
        if (status_rd_in) begin
            pf_read_next = 1'b1;
        end
        if (hit_gcfg && wr_data_in[`SGC_BIT_PFCLR]) begin
            pf_read_next = 1'b0;
        end else if (pf_read_reg && gcfg_reg[`SGC_BIT_PFCLR] && state_next == state_reg
                     && !hit_gcfg) begin
            gcfg_next[`SGC_BIT_PFCLR] = 1'b0;
            pf_read_next = 1'b0;
        end
    end

    assign rd_next   = rd_en_in ? rd_sel : rd_reg;
    // sensed pins shown in status bits 7 and 6, flag in bit 0
    assign stat_next = {pin_level[1], pin_level[0], 5'h00, pf_reg};
    // pin bits kept inverted so the enables leave a flop with no gate after it
    assign out_next  = {
        !gcfg_reg[`SGC_BIT_GP2],
        !gcfg_reg[`SGC_BIT_GP1],
        hold_bit || state_reg == SGC_HOLD,
        state_reg == SGC_INIT,
        agc_off,
        gcfg_reg[`SGC_BIT_SLOW] && !agc_off,
        gcfg_reg[`SGC_BIT_IFSEL],
        gain_reg[`SGC_BIT_LVLSHIFT]
    };

    // sequencing state and re-init counter
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg      <= SGC_RUN;
            cnt_reg        <= 4'h0;
        end else begin
            state_reg      <= state_next;
            cnt_reg        <= cnt_next;
        end
    end

    // host-written registers
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            gcfg_reg       <= `SGC_GCFG_RESET;
            gain_reg       <= `SGC_GAIN_RESET;
            keep_reg       <= 8'h00;
        end else begin
            gcfg_reg       <= gcfg_next;
            gain_reg       <= gain_next;
            keep_reg       <= keep_next;
        end
    end

    // power-fail flag and the status-read tracker behind its clear bit
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pf_reg         <= 1'b0;
            pf_read_reg    <= 1'b0;
        end else begin
            pf_reg         <= pf_next;
            pf_read_reg    <= pf_read_next;
        end
    end

    // host-visible read data and status
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_reg         <= 8'h00;
            stat_reg       <= 8'h00;
        end else begin
            rd_reg         <= rd_next;
            stat_reg       <= stat_next;
        end
    end

    // function outputs, one cycle behind the registers
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            // default config with pin bits inverted is all zero: pins released
            out_reg        <= 8'h00;
            fcode_reg      <= 5'h00;
            agc_prev_reg   <= 1'b0;
        end else begin
            out_reg        <= out_next;
            // code 31 is 0 dB, code 0 is 24 dB; analog stage does the mapping
            fcode_reg      <= gain_reg[4:0];
            agc_prev_reg   <= agc_off;
        end
    end

    // pins cross in bit by bit; reset level is the released, pulled-up high
    wire [1:0] pin_raw = {gp_pin_two_in, gp_pin_one_in};
    for (genvar i = 0; i < 2; i++) begin : g_pin_sync
        logic sync0_reg;
        logic sync1_reg;
        always_ff @(posedge sys_clk_in or posedge rst_in) begin
            if (rst_in) begin
                sync0_reg <= 1'b1;
                sync1_reg <= 1'b1;
            end else begin
                sync0_reg <= pin_raw[i];
                sync1_reg <= sync0_reg;
            end
        end
        assign pin_level[i] = sync1_reg;
    end

    // loop code is a bus: a value is taken only once two settled stages agree,
    // so a code caught mid-change never lands in the gain register
    // limitation: a code changing every cycle is never taken
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            code_sync0_reg <= 5'h00;
            code_sync1_reg <= 5'h00;
            code_sync2_reg <= 5'h00;
            code_hold_reg  <= 5'h00;
            pfe_sync0_reg  <= 1'b0;
            pfe_sync1_reg  <= 1'b0;
        end else begin
            code_sync0_reg <= loop_gain_code_in;
            code_sync1_reg <= code_sync0_reg;
            code_sync2_reg <= code_sync1_reg;
            if (code_sync1_reg == code_sync2_reg) begin
                code_hold_reg <= code_sync2_reg;
            end
            pfe_sync0_reg  <= power_fail_event_in;
            pfe_sync1_reg  <= pfe_sync0_reg;
        end
    end

    // open drain: a zero bit pulls low, a one bit releases the pin
    assign gp_pin_two_oe_out        = out_reg[7];
    assign gp_pin_one_oe_out        = out_reg[6];
    // drive level is always low; only the enable moves
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            gp_pin_one_o_out <= 1'b0;
            gp_pin_two_o_out <= 1'b0;
        end else begin
            gp_pin_one_o_out <= 1'b0;
            gp_pin_two_o_out <= 1'b0;
        end
    end
    assign low_power_hold_out       = out_reg[5];
    assign init_busy_out            = out_reg[4];
    assign gain_loop_disable_out    = out_reg[3];
    assign gain_loop_slow_decay_out = out_reg[2];
    assign if_input_choice_out      = out_reg[1];
    assign input_level_shift_out    = out_reg[0];
    assign fixed_gain_code_out      = fcode_reg;
    assign power_fail_flag_out      = pf_reg;
    assign rd_data_out              = rd_reg;
    assign status_out               = stat_reg;

endmodule // sgc_regs

// File: tb/sgc_regs_checker.sv
// port checks for the sound-IF configuration registers
`timescale 1ns/10ps
module sgc_regs_checker #(
    parameter int INIT_CYCLES = 4
) (
    input wire logic       sys_clk_in,               // clock
    input wire logic       rst_in,                   // reset
    input wire logic       wr_en_in,                 // write
    input wire logic [7:0] addr_in,                  // address
    input wire logic [7:0] wr_data_in,               // data
    input wire logic       gp_pin_one_oe_out,        // pin 1
    input wire logic       gp_pin_two_oe_out,        // pin 2
    input wire logic       low_power_hold_out,       // standby
    input wire logic       init_busy_out,            // re-init
    input wire logic       gain_loop_disable_out,    // fixed gain
    input wire logic       gain_loop_slow_decay_out, // slow
    input wire logic       if_input_choice_out,      // IF select
    input wire logic       input_level_shift_out,    // attenuator
    input wire logic [4:0] fixed_gain_code_out       // gain code
);
    logic [1:0] wr_hist_reg;
    logic [3:0] busy_cnt_reg;
    logic [3:0] busy_cnt_next;
    // refusal shows late, so writes close behind another are not judged
    wire idle_ok = !init_busy_out && !low_power_hold_out && wr_hist_reg == 2'b00;
    wire cfg_wr  = wr_en_in && addr_in == 8'h01 && idle_ok;
    wire cfg_ok  = cfg_wr && wr_data_in[5:4] == 2'b00;
    wire init_ok = cfg_wr && wr_data_in[5:4] == 2'b01;
    assign busy_cnt_next = init_busy_out ? busy_cnt_reg + 4'h1 : 4'h0;
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_hist_reg  <= 2'b00;
            busy_cnt_reg <= 4'h0;
        end else begin
            wr_hist_reg  <= {wr_hist_reg[0], wr_en_in};
            busy_cnt_reg <= busy_cnt_next;
        end
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    property p_reset; $fell(rst_in) |-> !gp_pin_one_oe_out && !gp_pin_two_oe_out; endproperty
    a_reset: assert property (p_reset) else $error("pins driven after reset");
    property p_gp; cfg_ok |-> ##3 {gp_pin_two_oe_out, gp_pin_one_oe_out} ==
        ~$past(wr_data_in[7:6], 3); endproperty
    a_gp: assert property (p_gp) else $error("pin drive wrong");
    property p_slow; cfg_ok |-> ##3 gain_loop_slow_decay_out ==
        ($past(wr_data_in[2], 3) && !$past(wr_data_in[1], 3)); endproperty
    a_slow: assert property (p_slow) else $error("slow decay wrong");
    property p_dis; cfg_ok |-> ##3 gain_loop_disable_out == $past(wr_data_in[1], 3); endproperty
    a_dis: assert property (p_dis) else $error("gain loop disable wrong");
    property p_sel; cfg_ok |-> ##3 if_input_choice_out == $past(wr_data_in[0], 3); endproperty
    a_sel: assert property (p_sel) else $error("IF input choice wrong");
    property p_init_run; init_ok |-> ##3 init_busy_out; endproperty
    a_init_run: assert property (p_init_run) else $error("re-init not started");
    property p_init_len; $fell(init_busy_out) |-> busy_cnt_reg == INIT_CYCLES; endproperty
    a_init_len: assert property (p_init_len) else $error("re-init length wrong");
    property p_init_keep; init_ok && wr_data_in[0] |-> ##8 if_input_choice_out; endproperty
    a_init_keep: assert property (p_init_keep) else $error("written bit lost");
    property p_gain; wr_en_in && addr_in == 8'h00 && idle_ok |->
        ##3 {input_level_shift_out, fixed_gain_code_out} == $past(wr_data_in[5:0], 3); endproperty
    a_gain: assert property (p_gain) else $error("gain outputs wrong");
endmodule // sgc_regs_checker
bind sgc_regs sgc_regs_checker #(.INIT_CYCLES(INIT_CYCLES)) sgc_regs_checker_inst (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .wr_en_in(wr_en_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .gp_pin_one_oe_out(gp_pin_one_oe_out),
    .gp_pin_two_oe_out(gp_pin_two_oe_out), .low_power_hold_out(low_power_hold_out),
    .init_busy_out(init_busy_out), .gain_loop_disable_out(gain_loop_disable_out),
    .gain_loop_slow_decay_out(gain_loop_slow_decay_out),
    .if_input_choice_out(if_input_choice_out), .input_level_shift_out(input_level_shift_out),
    .fixed_gain_code_out(fixed_gain_code_out));

// File: tb/sgc_pin_env.sv
// far side of the general-purpose pins: pull-up wires, outside pull-down
`timescale 1ns/10ps
module sgc_pin_env (
    input  wire logic [1:0] oe_in,    // device drives
    input  wire logic [1:0] drive_in, // device level
    input  wire logic [1:0] pull_in,  // outside pulls low
    output logic [1:0]      level_out // wire level
);
    // released and unpulled pins float up to the resistor level
    assign level_out = ~pull_in & (~oe_in | drive_in);
endmodule // sgc_pin_env

// File: tb/sound_if_general_config_regs_bench.sv
// self-checking bench for the sound-IF configuration registers
`timescale 1ns/10ps
module sound_if_general_config_regs_bench;
    logic       clk, rst, wen, ren, srd, pfe;
    logic [7:0] addr, wdat, rdat, stat, d, e;
    logic [4:0] lgc, fgc;
    logic [1:0] pull, oe, drv, pin;
    logic       hold, busy, dis, slow, sel, lvl, pf;
    int         n_fail, tests_run;
    sgc_regs sgc_regs_inst (.sys_clk_in(clk), .rst_in(rst), .wr_en_in(wen), .rd_en_in(ren),
        .addr_in(addr), .wr_data_in(wdat), .status_rd_in(srd), .power_fail_event_in(pfe),
        .loop_gain_code_in(lgc), .gp_pin_one_in(pin[0]), .gp_pin_two_in(pin[1]),
        .rd_data_out(rdat), .status_out(stat), .gp_pin_one_oe_out(oe[0]),
        .gp_pin_two_oe_out(oe[1]), .gp_pin_one_o_out(drv[0]), .gp_pin_two_o_out(drv[1]),
        .low_power_hold_out(hold), .init_busy_out(busy), .gain_loop_disable_out(dis),
        .gain_loop_slow_decay_out(slow), .if_input_choice_out(sel),
        .input_level_shift_out(lvl), .fixed_gain_code_out(fgc), .power_fail_flag_out(pf));
    sgc_pin_env sgc_pin_env_inst (.oe_in(oe), .drive_in(drv), .pull_in(pull), .level_out(pin));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    function automatic logic [7:0] f_outs(input logic [7:0] c);
        return {3'h0, ~c[7], ~c[6], c[2] & ~c[1], c[1], c[0]};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        addr = a;
        wdat = v;
        wen = 1'b1;
        tick(1);
        wen = 1'b0;
        tick(3);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        ren = 1'b1;
        tick(1);
        ren = 1'b0;
        tick(1);
        chk("rd_data", rdat, exp);
    endtask
    task automatic summarize();
        if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #40000;
        n_fail++;
        summarize();
    end
    initial begin
        {rst, wen, ren, srd, pfe, addr, wdat, lgc, pull} = {5'h10, 23'h0};
        n_fail = 0;
        tests_run = 0;
        d = 8'($urandom(32'h6fce));
        tick(20);
        rst = 1'b0;
        tick(1);
        rd(8'h01, 8'hC0);
        rd(8'h00, 8'h00);
        rd(8'h05, 8'h00);
        for (int i = 0; i < 10; i++) begin
            d = (i == 0) ? 8'hC6 : (i == 1) ? 8'h05 : 8'($urandom) & 8'hC7;
            pull = 2'($urandom);
            wr(8'h01, d);
            tick(4);
            e = f_outs(d);
            chk("pins", {6'h0, oe}, {6'h0, e[4:3]});
            chk("slow", {7'h0, slow}, {7'h0, e[2]});
            chk("dis_sel", {6'h0, dis, sel}, {6'h0, e[1:0]});
            chk("status", stat, {d[7] & ~pull[1], d[6] & ~pull[0], 6'h00});
            rd(8'h01, d);
        end
        pull = 2'h0;
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 8'hFF : (i == 1) ? 8'hC0 : 8'($urandom);
            wr(8'h01, {6'h30, i[0], 1'b0});
            wr(8'h00, d);
            chk("gain", {2'h0, lvl, fgc}, d & 8'h3F);
            rd(8'h00, d & 8'h3F);
        end
        wr(8'h01, 8'hC0);
        wr(8'h00, 8'h00);
        lgc = 5'($urandom);
        tick(4);
        wr(8'h01, 8'hC2);
        rd(8'h00, {3'h0, lgc});
        wr(8'h00, 8'h2A);
        wr(8'h01, 8'h11);
        tick(8);
        rd(8'h01, 8'hC1);
        rd(8'h00, 8'h00);
        pfe = 1'b1;
        tick(2);
        pfe = 1'b0;
        tick(5);
        chk("status", stat, 8'hC1);
        wr(8'h01, 8'hC8);
        tick(1);
        chk("flag", {7'h0, pf}, 8'h00);
        rd(8'h01, 8'hC8);
        srd = 1'b1;
        tick(1);
        srd = 1'b0;
        tick(3);
        rd(8'h01, 8'hC0);
        wr(8'h01, 8'hE5);
        chk("hold", {7'h0, hold}, 8'h01);
        wr(8'h00, 8'h1F);
        wr(8'h01, 8'h03);
        chk("hold", {7'h0, hold}, 8'h00);
        rd(8'h01, 8'hC0);
        rd(8'h00, 8'h00);
        summarize();
    end
endmodule // sound_if_general_config_regs_bench
